/* lcc_pkg.sv */
// constants for the link capability and link control register pair
package lcc_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 32;
   localparam int          CTRL_W        = 16;
   localparam logic [7:0]  OFS_LINK_CAP  = 8'hbc;
   localparam logic [7:0]  OFS_LINK_CTRL = 8'hc0;

   // ----------------------------------------
   // capability word fields
   // ----------------------------------------
   localparam int          CAP_SPEED_LSB = 0;
   localparam int          CAP_WIDTH_LSB = 4;
   localparam int          CAP_ASPM_LSB  = 10;
   localparam int          CAP_L0S_LSB   = 12;
   localparam int          CAP_L1_LSB    = 15;
   localparam int          CAP_CPM_BIT   = 18;
   localparam int          CAP_DLLA_BIT  = 20;
   localparam int          CAP_PORT_LSB  = 24;
   localparam logic [3:0]  SPEED_2G5     = 4'h1;
   localparam logic [5:0]  WIDTH_X1      = 6'h01;
   localparam logic [1:0]  ASPM_L0S_L1   = 2'h3;
   localparam logic [2:0]  L0S_EXIT_LAT  = 3'h3;
   localparam logic [2:0]  L1_LAT_NO_CPM = 3'h0;
   localparam logic [2:0]  L1_LAT_CPM    = 3'h6;
   localparam logic        DLLA_CAPABLE  = 1'h0;
   localparam logic [7:0]  PORT_NUMBER   = 8'h00;

   // ----------------------------------------
   // control word fields
   // ----------------------------------------
   localparam int          CTL_ASPM_LSB  = 0;
   localparam int          CTL_CCLK_BIT  = 6;
   localparam int          CTL_XSYNC_BIT = 7;
   localparam int          CTL_CPM_BIT   = 8;
   localparam logic [1:0]  ASPM_RST      = 2'h0;
   localparam logic        BIT_RST       = 1'h0;

   // ----------------------------------------
   // strap capture
   // ----------------------------------------
   localparam logic [1:0]  STRAP_CPM_ON  = 2'h0;

   typedef enum logic {LCC_ST_WAIT, LCC_ST_DONE} lcc_strap_st_t;
endpackage : lcc_pkg

/* lcc_strap_if.sv */
// strap result passed from the sampler to the register bank
`timescale 1ns/100ps
interface lcc_strap_if;
   logic cpm_on;
   logic captured;
   modport src  (output cpm_on, output captured);
   modport sink (input  cpm_on, input  captured);
endinterface : lcc_strap_if

/* lcc_strap.sv */
// samples the bus request straps once after reset release
`timescale 1ns/100ps
module lcc_strap (
   input  wire logic        i_sys_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_clk_en,
   input  wire logic [1:0]  i_req_n,
   lcc_strap_if.src         strap
);
   // ----------------------------------------
   // pin synchroniser
   // ----------------------------------------
   logic [1:0]              sync1;
   logic [1:0]              sync2;
   lcc_pkg::lcc_strap_st_t  state;
   lcc_pkg::lcc_strap_st_t  next_state;
   logic                    cpm_on;
   logic                    next_cpm_on;

   // no reset here: the flops must keep tracking the pins while reset is held,
   // otherwise the capture would always see the cleared value
   always_ff @(posedge i_sys_clk) begin
      if (i_clk_en) begin
         sync1 <= i_req_n;
         sync2 <= sync1;
      end
   end

   // ----------------------------------------
   // one-shot capture
   // ----------------------------------------
   // the synchroniser is primed during reset, so its output on the first
   // enabled edge after release is the level held at the release
   always_comb begin
      next_state  = state;
      next_cpm_on = cpm_on;
      unique case (state)
         lcc_pkg::LCC_ST_WAIT: begin
            next_cpm_on = (sync2 == lcc_pkg::STRAP_CPM_ON);
            next_state  = lcc_pkg::LCC_ST_DONE;
         end
         lcc_pkg::LCC_ST_DONE: begin
            next_state  = lcc_pkg::LCC_ST_DONE;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state  <= lcc_pkg::LCC_ST_WAIT;
         cpm_on <= 1'h0;
      end else if (i_clk_en) begin
         state  <= next_state;
         cpm_on <= next_cpm_on;
      end
   end

   assign strap.cpm_on   = cpm_on;
   assign strap.captured = (state == lcc_pkg::LCC_ST_DONE);
endmodule : lcc_strap

/* lcc_link_regs.sv */
// link capability and link control configuration registers
//
// Functional notes
// - max link speed bits 3:0 read constant 0001, writes ignored
// - max link width bits 9:4 read one-hot width code, read-only
// - aspm support bits 11:10 read 11; l0s exit latency reads 3h
// - l1 exit latency bits 17:15 read 0h, or 6h when strap enables clock pm
// - capability bit 18 reads 1 only when strap enables clock pm
// - request pins 1:0 both low at reset release enable clock pm
// - bit 20, reserved bits 19, 23:21 and port number 31:24 read zero
// - control bits 1:0 writable aspm control, reset 00
// - control bits 2, 3 and 15:9 read zero
// - control bit 8 writable only when strap enables clock pm, reset 0
`timescale 1ns/100ps
module lcc_link_regs #(
   parameter logic [5:0] MAX_WIDTH = lcc_pkg::WIDTH_X1
) (
   input  wire logic                        i_sys_clk,
   input  wire logic                        i_nrst,
   input  wire logic                        i_clk_en,
   input  wire logic [lcc_pkg::ADDR_W-1:0]  i_addr,
   input  wire logic [lcc_pkg::DATA_W-1:0]  i_wdata,
   input  wire logic                        i_wr,
   input  wire logic                        i_rd,
   output logic      [lcc_pkg::DATA_W-1:0]  o_rdata,
   input  wire logic [1:0]                  i_req_n,
   output logic                             o_strap_done,
   output logic                             o_cpm_capable,
   output logic      [1:0]                  o_aspm_ctrl,
   output logic                             o_common_clk,
   output logic                             o_ext_sync,
   output logic                             o_cpm_enable
);
   // ----------------------------------------
   // strap sampler
   // ----------------------------------------
   lcc_strap_if strap ();

   lcc_strap u_strap (
      .i_sys_clk (i_sys_clk),
      .i_nrst    (i_nrst),
      .i_clk_en  (i_clk_en),
      .i_req_n   (i_req_n),
      .strap     (strap.src)
   );

   // ----------------------------------------
   // capability word
   // ----------------------------------------
   logic [lcc_pkg::DATA_W-1:0] cap_word;

   always_comb begin
      cap_word = '0; // reserved bits 19, 23:21 stay zero
      cap_word[lcc_pkg::CAP_SPEED_LSB +: 4] = lcc_pkg::SPEED_2G5;
      cap_word[lcc_pkg::CAP_WIDTH_LSB +: 6] = MAX_WIDTH;
      cap_word[lcc_pkg::CAP_ASPM_LSB +: 2]  = lcc_pkg::ASPM_L0S_L1;
      cap_word[lcc_pkg::CAP_L0S_LSB +: 3]   = lcc_pkg::L0S_EXIT_LAT;
      cap_word[lcc_pkg::CAP_L1_LSB +: 3]    = strap.cpm_on ? lcc_pkg::L1_LAT_CPM
                                                           : lcc_pkg::L1_LAT_NO_CPM;
      cap_word[lcc_pkg::CAP_CPM_BIT]        = strap.cpm_on;
      cap_word[lcc_pkg::CAP_DLLA_BIT]       = lcc_pkg::DLLA_CAPABLE;
      cap_word[lcc_pkg::CAP_PORT_LSB +: 8]  = lcc_pkg::PORT_NUMBER;
   end

   // ----------------------------------------
   // control word storage
   // ----------------------------------------
   logic [1:0] aspm_ctrl;
   logic       common_clk;
   logic       ext_sync;
   logic       cpm_enable;
   logic [1:0] next_aspm_ctrl;
   logic       next_common_clk;
   logic       next_ext_sync;
   logic       next_cpm_enable;
   logic       ctrl_wr;

   assign ctrl_wr = i_wr && (i_addr == lcc_pkg::OFS_LINK_CTRL);

   // writes to the capability word decode to nothing at all
   always_comb begin
      next_aspm_ctrl  = aspm_ctrl;
      next_common_clk = common_clk;
      next_ext_sync   = ext_sync;
      next_cpm_enable = cpm_enable;
      if (ctrl_wr) begin
         next_aspm_ctrl  = i_wdata[lcc_pkg::CTL_ASPM_LSB +: 2];
         next_common_clk = i_wdata[lcc_pkg::CTL_CCLK_BIT];
         next_ext_sync   = i_wdata[lcc_pkg::CTL_XSYNC_BIT];
         // without the strap the bit is read-only and stays at reset value
         if (strap.cpm_on) begin
            next_cpm_enable = i_wdata[lcc_pkg::CTL_CPM_BIT];
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         aspm_ctrl  <= lcc_pkg::ASPM_RST;
         common_clk <= lcc_pkg::BIT_RST;
         ext_sync   <= lcc_pkg::BIT_RST;
         cpm_enable <= lcc_pkg::BIT_RST;
      end else if (i_clk_en) begin
         aspm_ctrl  <= next_aspm_ctrl;
         common_clk <= next_common_clk;
         ext_sync   <= next_ext_sync;
         cpm_enable <= next_cpm_enable;
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   logic [lcc_pkg::CTRL_W-1:0] ctrl_word;
   logic [lcc_pkg::DATA_W-1:0] rdata;
   logic [lcc_pkg::DATA_W-1:0] next_rdata;

   always_comb begin
      ctrl_word = '0; // bits 2, 3, 4, 5 and 15:9 read zero
      ctrl_word[lcc_pkg::CTL_ASPM_LSB +: 2] = aspm_ctrl;
      ctrl_word[lcc_pkg::CTL_CCLK_BIT]      = common_clk;
      ctrl_word[lcc_pkg::CTL_XSYNC_BIT]     = ext_sync;
      ctrl_word[lcc_pkg::CTL_CPM_BIT]       = cpm_enable;
   end

   // data stand for the single cycle after the strobe, zero otherwise;
   // unmapped addresses answer zero
   always_comb begin
      next_rdata = '0;
      if (i_rd) begin
         if (i_addr == lcc_pkg::OFS_LINK_CAP) begin
            next_rdata = cap_word;
         end else if (i_addr == lcc_pkg::OFS_LINK_CTRL) begin
            next_rdata = {{(lcc_pkg::DATA_W-lcc_pkg::CTRL_W){1'b0}}, ctrl_word};
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rdata <= '0;
      end else if (i_clk_en) begin
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign o_rdata       = rdata;
   assign o_strap_done  = strap.captured;
   assign o_cpm_capable = strap.cpm_on;
   assign o_aspm_ctrl   = aspm_ctrl;
   assign o_common_clk  = common_clk;
   assign o_ext_sync    = ext_sync;
   assign o_cpm_enable  = cpm_enable;
endmodule : lcc_link_regs

/* lcc_link_props.sv */
// assertions for the link capability and link control registers
`timescale 1ns/100ps
module lcc_link_props #(
   parameter logic [5:0] MAX_WIDTH = 6'h01
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_clk_en,
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic [31:0] o_rdata,
   input  wire logic [1:0]  i_req_n,
   input  wire logic        o_strap_done,
   input  wire logic        o_cpm_capable,
   input  wire logic [1:0]  o_aspm_ctrl,
   input  wire logic        o_common_clk,
   input  wire logic        o_ext_sync,
   input  wire logic        o_cpm_enable
);
   // ----------------
   // checks
   // ----------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   logic rd_cap, rd_ctl, wr_ctl;
   assign rd_cap = i_clk_en && i_rd && i_addr == 8'hbc;
   assign rd_ctl = i_clk_en && i_rd && i_addr == 8'hc0;
   assign wr_ctl = i_clk_en && i_wr && i_addr == 8'hc0;
   a_cap_word: assert property (rd_cap |=> o_rdata == {13'h0, o_cpm_capable,
      (o_cpm_capable ? 3'h6 : 3'h0), 3'h3, 2'h3, MAX_WIDTH, 4'h1})
      else $error("capability word wrong");
   a_ctl_word: assert property (rd_ctl |=> o_rdata == {23'h0, o_cpm_enable, o_ext_sync,
      o_common_clk, 4'h0, o_aspm_ctrl}) else $error("control word wrong");
   a_ctl_write: assert property (wr_ctl |=> o_aspm_ctrl == $past(i_wdata[1:0])
      && {o_ext_sync, o_common_clk} == $past(i_wdata[7:6])) else $error("control write lost");
   a_cpm_write: assert property (wr_ctl && o_cpm_capable |=> o_cpm_enable == $past(i_wdata[8]))
      else $error("clock pm enable not stored");
   a_cpm_locked: assert property (!o_cpm_capable |-> !o_cpm_enable)
      else $error("clock pm enable set without strap");
   a_ctl_hold: assert property (!wr_ctl |=> $stable({o_aspm_ctrl, o_common_clk, o_ext_sync,
      o_cpm_enable})) else $error("control changed without write");
   a_rdata_idle: assert property (i_clk_en && !i_rd |=> o_rdata == 32'h0)
      else $error("read data outside answer cycle");
   a_unmapped_zero: assert property (i_clk_en && i_rd && !rd_cap && !rd_ctl |=> o_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_strap_first: assert property ($rose(o_strap_done) |-> o_cpm_capable == (i_req_n == 2'h0))
      else $error("strap sampled wrong");
   a_strap_kept: assert property (o_strap_done |=> o_strap_done && $stable(o_cpm_capable))
      else $error("strap result changed");
   c_cap_on: cover property (rd_cap && o_cpm_capable);
   c_cpm_wr: cover property (wr_ctl && o_cpm_capable);
   c_cpm_lock: cover property (wr_ctl && !o_cpm_capable);
endmodule : lcc_link_props

bind lcc_link_regs lcc_link_props #(.MAX_WIDTH(MAX_WIDTH)) u_props (.*);

/* lcc_host.sv */
// host-side model issuing configuration reads and writes
`timescale 1ns/100ps
module lcc_host (
   input  wire logic        i_sys_clk,
   output logic      [7:0]  o_addr,
   output logic      [31:0] o_wdata,
   output logic             o_wr,
   output logic             o_rd
);
   // ----------------
   // bus access
   // ----------------
   initial {o_addr, o_wdata, o_wr, o_rd} = '0;
   // one strobe cycle then a quiet one; released lines show inverted junk
   task acc(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge i_sys_clk);
      o_addr  <= a;
      o_wdata <= v;
      o_wr    <= w;
      o_rd    <= !w;
      @(posedge i_sys_clk);
      o_addr  <= ~a;
      o_wdata <= ~v;
      o_wr    <= 1'b0;
      o_rd    <= 1'b0;
   endtask : acc
endmodule : lcc_host

/* lcc_link_regs_test.sv */
// self-checking bench for the link register pair
`timescale 1ns/100ps
module lcc_link_regs_test;
   logic        i_sys_clk, i_nrst, i_clk_en, i_wr, i_rd, rd_pend, cp;
   logic        o_strap_done, o_cpm_capable, o_common_clk, o_ext_sync, o_cpm_enable;
   logic [1:0]  i_req_n, o_aspm_ctrl, s;
   logic [7:0]  i_addr;
   logic [31:0] i_wdata, o_rdata, d, cap, exp_q[$];
   int          n_errors, n_tests, cyc;
   lcc_host host (.i_sys_clk(i_sys_clk), .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr),
                  .o_rd(i_rd));
   lcc_link_regs DUT (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_clk_en(i_clk_en),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_req_n(i_req_n), .o_strap_done(o_strap_done), .o_cpm_capable(o_cpm_capable),
      .o_aspm_ctrl(o_aspm_ctrl), .o_common_clk(o_common_clk), .o_ext_sync(o_ext_sync),
      .o_cpm_enable(o_cpm_enable));
   // ----------------
   // helpers
   // ----------------
   task check(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   task rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      host.acc(1'b0, a, 32'h0);
   endtask : rd
   task rst(input logic [1:0] st);
      i_nrst  <= 1'b0;
      i_req_n <= st;
      repeat (6) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
   endtask : rst
   task report_and_stop;
      $display("mismatches %0d of %0d checks", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   // ----------------
   // clock, monitor, sequence
   // ----------------
   initial begin
      i_sys_clk = 1'b0;
      forever #50 i_sys_clk = ~i_sys_clk;
   end
   initial {cyc, rd_pend} = '0;
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      if (rd_pend)
         check("rdata", exp_q.pop_front(), o_rdata);
      rd_pend <= i_rd;
      if (cyc > 2000) begin
         n_errors++;
         report_and_stop;
      end
   end
   initial begin
      {i_nrst, n_errors, n_tests} = '0;
      i_clk_en = 1'b1;
      i_req_n  = 2'h3;
      void'($urandom(52576));
      for (int ph = 0; ph < 2; ph++) begin
         s = ph ? 2'($urandom % 3) + 2'h1 : 2'h0;
         rst(s);
         cp = (s == 2'h0);
         check("strap", {30'h0, 1'b1, cp}, {30'h0, o_strap_done, o_cpm_capable});
         i_req_n <= ~s; // late pin change must be ignored
         cap = {13'h0, cp, (cp ? 3'h6 : 3'h0), 3'h3, 2'h3, 6'h01, 4'h1};
         rd(8'hc0, 32'h0);
         rd(8'hbc, cap);
         host.acc(1'b1, 8'hbc, $urandom);
         rd(8'hbc, cap);
         for (int a = 0; a < 4; a++) begin
            d = $urandom;
            d[1:0] = 2'(a);
            host.acc(1'b1, 8'hc0, d);
            rd(8'hc0, {23'h0, cp & d[8], d[7:6], 4'h0, d[1:0]});
         end
         i_clk_en <= 1'b0;
         host.acc(1'b1, 8'hc0, ~d); // frozen clock, write must be lost
         i_clk_en <= 1'b1;
         rd(8'hc0, {23'h0, cp & d[8], d[7:6], 4'h0, d[1:0]});
         rd(8'hc4 + 8'($urandom % 8) * 8'h4, 32'h0);
         @(posedge i_sys_clk);
      end
      repeat (3) @(posedge i_sys_clk);
      report_and_stop;
   end
endmodule : lcc_link_regs_test
